/* File: include/cks_pkg.sv */
package cks_pkg;
  // register byte offsets
  localparam logic [7:0] OSC_CTRL_OFS = 8'h00;
  localparam logic [7:0] T1_CTRL_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] CONFIG_OFS = 8'h0C;
  // oscillator_control_reg field positions
  localparam int SCS_LSB = 0;
  localparam int FAST_OSC_STABLE_FLAG_BIT = 2;
  localparam int PRIMARY_TIMEOUT_FLAG_BIT = 3;
  localparam int INTERNAL_FREQ_SELECT_LSB = 4;
  // timer_one_control_reg field positions
  localparam int T1EN_BIT = 3;
  localparam int SECONDARY_RUNNING_FLAG_BIT = 6;
  // config field positions
  localparam int FOSC_LSB = 0;
  localparam int WAKE_BIT = 4;
  // reset values
  localparam logic [1:0] SCS_RESET = 2'h0;
  localparam logic [2:0] INTERNAL_FREQ_SELECT_RESET = 3'h0;
  localparam logic [2:0] FOSC_RESET = 3'h2;
  // source select codes
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_SECONDARY = 2'h1;
  localparam logic [1:0] SEL_INTERNAL = 2'h2;
  localparam logic [1:0] SEL_RESERVED = 2'h3;
  // primary oscillator kinds
  localparam logic [2:0] FOSC_LOW_POWER_CRYSTAL = 3'h0;
  localparam logic [2:0] FOSC_STANDARD_CRYSTAL = 3'h1;
  localparam logic [2:0] FOSC_HIGH_SPEED_CRYSTAL = 3'h2;
  localparam logic [2:0] FOSC_EXTERNAL_CLOCK = 3'h3;
  localparam logic [2:0] FOSC_RC_OSC = 3'h4;
  localparam logic [2:0] FOSC_INTERNAL = 3'h5;
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SETTLE_US = 4000;
  localparam int SETTLE_CYC = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int CPU_DLY_MAX_US = 10;
  localparam int CPU_DLY_CYC = CPU_DLY_MAX_US * (CLK_HZ / 1_000_000);
  localparam int OST_COUNT = 1024;
  localparam int Q1_EDGES = 8;
  // sequencer states, gray along the usual path
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_OST = 3'b001,
    ST_HOLD = 3'b011,
    ST_CPU = 3'b010
  } cks_state_t;
endpackage

/* File: src/cks_sequencer.sv */
`timescale 1ns/10ps
module cks_sequencer
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hsel,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic primary_clk_pin,
  input wire logic internal_clk_pin,
  input wire logic secondary_clk_pin,
  input wire logic wake_event,
  output logic [1:0] active_source,
  output logic q1_hold,
  output logic primary_osc_on,
  output logic internal_osc_on,
  output logic secondary_osc_on
);
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic [2:0] internal_freq_select;
    logic primary_timeout_flag;
    logic fast_osc_stable_flag;
    logic secondary_osc_enable;
    logic secondary_running_flag;
    logic [2:0] fosc;
    cks_pkg::cks_state_t state;
    logic [1:0] active;
    logic [1:0] target;
    logic [10:0] ost_cnt;
    logic [3:0] edge_cnt;
    logic [7:0] cpu_cnt;
    logic [16:0] settle_cnt;
    logic settling;
    logic sec_keep;
    logic [2:0] p_sync;
    logic [2:0] i_sync;
    logic [2:0] s_sync;
    logic wake_s1;
    logic wake_s2;
    logic ph_write;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic pri_on;
  } cks_regs_t;

  cks_regs_t r;
  cks_regs_t next_r;
  logic pri_fall;
  logic int_fall;
  logic sec_fall;
  logic tgt_fall;
  logic crystal;
  logic [1:0] req;
  logic [1:0] resolved;
  logic start;

  // falling edges seen after two-flop sync (third stage only for edge)
  assign pri_fall = r.p_sync[2] & ~r.p_sync[1];
  assign int_fall = r.i_sync[2] & ~r.i_sync[1];
  assign sec_fall = r.s_sync[2] & ~r.s_sync[1];
  assign crystal = (r.fosc == cks_pkg::FOSC_LOW_POWER_CRYSTAL) |
                   (r.fosc == cks_pkg::FOSC_STANDARD_CRYSTAL) |
                   (r.fosc == cks_pkg::FOSC_HIGH_SPEED_CRYSTAL);

  // edges of whichever source is being switched to
  always_comb
  begin
    unique case (r.target)
      cks_pkg::SEL_SECONDARY: tgt_fall = sec_fall;
      cks_pkg::SEL_INTERNAL: tgt_fall = int_fall;
      default: tgt_fall = pri_fall;
    endcase
  end

  // select resolution against secondary enable
  always_comb
  begin
    req = hwdata[cks_pkg::SCS_LSB +: 2];
    resolved = req;
    if (!r.secondary_osc_enable)
    begin
      // bit 0 cannot stick without the secondary enabled
      resolved = {req[1], 1'b0};
    end
    else if (req == cks_pkg::SEL_RESERVED)
    begin
      resolved = r.clock_source_select; // reserved code ignored
    end
  end

  always_comb
  begin
    next_r = r;
    start = 1'b0;
    next_r.p_sync = {r.p_sync[1:0], primary_clk_pin};
    next_r.i_sync = {r.i_sync[1:0], internal_clk_pin};
    next_r.s_sync = {r.s_sync[1:0], secondary_clk_pin};
    next_r.wake_s1 = wake_event;
    next_r.wake_s2 = r.wake_s1;
    // ahb-lite: zero wait states, read data prepared in address phase
    next_r.ph_write = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      next_r.ph_write = hwrite;
      next_r.ph_addr = haddr[7:0];
      next_r.rdata = 32'h0;
      unique case (haddr[7:0])
        cks_pkg::OSC_CTRL_OFS:
        begin
          next_r.rdata[cks_pkg::SCS_LSB +: 2] = r.clock_source_select;
          next_r.rdata[cks_pkg::FAST_OSC_STABLE_FLAG_BIT] = r.fast_osc_stable_flag;
          next_r.rdata[cks_pkg::PRIMARY_TIMEOUT_FLAG_BIT] = r.primary_timeout_flag;
          next_r.rdata[cks_pkg::INTERNAL_FREQ_SELECT_LSB +: 3] = r.internal_freq_select;
        end
        cks_pkg::T1_CTRL_OFS:
        begin
          next_r.rdata[cks_pkg::T1EN_BIT] = r.secondary_osc_enable;
          next_r.rdata[cks_pkg::SECONDARY_RUNNING_FLAG_BIT] = r.secondary_running_flag;
        end
        cks_pkg::STATUS_OFS:
          next_r.rdata[2:0] = {r.state};
        cks_pkg::CONFIG_OFS:
          next_r.rdata[cks_pkg::FOSC_LSB +: 3] = r.fosc;
        default: next_r.rdata = 32'h0;
      endcase
    end
    // register writes land in the data phase
    if (r.ph_write)
    begin
      unique case (r.ph_addr)
        cks_pkg::OSC_CTRL_OFS:
        begin
          next_r.internal_freq_select = hwdata[cks_pkg::INTERNAL_FREQ_SELECT_LSB +: 3];
          next_r.clock_source_select = resolved;
        end
        cks_pkg::T1_CTRL_OFS:
        begin
          next_r.secondary_osc_enable = hwdata[cks_pkg::T1EN_BIT];
          if (!hwdata[cks_pkg::T1EN_BIT] &&
              r.clock_source_select[0])
          begin
            next_r.clock_source_select[0] = 1'b0;
            next_r.sec_keep = 1'b1;
          end
        end
        cks_pkg::CONFIG_OFS:
          next_r.fosc = hwdata[cks_pkg::FOSC_LSB +: 3];
        default: next_r.fosc = r.fosc;
      endcase
    end
    // 4 ms settling of the fast internal source
    if (r.settling)
    begin
      if (r.settle_cnt == 17'(cks_pkg::SETTLE_CYC - 1))
      begin
        next_r.settling = 1'b0;
        next_r.fast_osc_stable_flag = 1'b1;
      end
      else
        next_r.settle_cnt = r.settle_cnt + 17'h1;
    end
    // sequencer
    unique case (r.state)
      cks_pkg::ST_RUN:
      begin
        if (r.wake_s2 && r.active != cks_pkg::SEL_PRIMARY)
        begin
          next_r.cpu_cnt = 8'h0;
          next_r.target = r.active;
          next_r.state = cks_pkg::ST_CPU;
        end
        else if (r.clock_source_select != r.active)
        begin
          start = 1'b1;
          next_r.target = r.clock_source_select;
          next_r.ost_cnt = 11'h0;
          next_r.edge_cnt = 4'h0;
          if (r.clock_source_select == cks_pkg::SEL_PRIMARY)
          begin
            next_r.pri_on = 1'b1;
            // crystals need a start-up count, others go to hold
            next_r.state = crystal ? cks_pkg::ST_OST
                                   : cks_pkg::ST_HOLD;
          end
          else if (r.clock_source_select == cks_pkg::SEL_INTERNAL &&
                   r.active == cks_pkg::SEL_PRIMARY &&
                   r.fosc == cks_pkg::FOSC_INTERNAL)
          begin
            // already on internal source: relabel only
            start = 1'b0;
            next_r.active = cks_pkg::SEL_INTERNAL;
          end
          else
          begin
            next_r.primary_timeout_flag = 1'b0;
            next_r.pri_on = 1'b0;
            next_r.state = cks_pkg::ST_HOLD;
            if (r.clock_source_select == cks_pkg::SEL_INTERNAL &&
                r.internal_freq_select != 3'h0)
            begin
              next_r.fast_osc_stable_flag = 1'b0;
              next_r.settling = 1'b1;
              next_r.settle_cnt = 17'h0;
            end
          end
        end
      end
      cks_pkg::ST_OST:
      begin
        // old source keeps clocking the core here
        if (pri_fall)
        begin
          if (r.ost_cnt == 11'(cks_pkg::OST_COUNT - 1))
            next_r.state = cks_pkg::ST_HOLD;
          else
            next_r.ost_cnt = r.ost_cnt + 11'h1;
        end
      end
      cks_pkg::ST_HOLD:
      begin
        if (tgt_fall)
        begin
          if (r.edge_cnt == 4'(cks_pkg::Q1_EDGES - 1))
          begin
            next_r.active = r.target;
            next_r.sec_keep = 1'b0;
            next_r.secondary_running_flag =
              (r.target == cks_pkg::SEL_SECONDARY);
            if (r.target == cks_pkg::SEL_PRIMARY)
              next_r.primary_timeout_flag = 1'b1;
            next_r.cpu_cnt = 8'h0;
            next_r.state = (r.active == cks_pkg::SEL_SECONDARY &&
                            r.target == cks_pkg::SEL_PRIMARY &&
                            !crystal) ? cks_pkg::ST_CPU
                                      : cks_pkg::ST_RUN;
          end
          else
            next_r.edge_cnt = r.edge_cnt + 4'h1;
        end
      end
      cks_pkg::ST_CPU:
      begin
        // core stays parked in Q1 for the longest start-up time
        // eight bits: the 250-cycle delay would wrap a narrower count
        if (r.cpu_cnt == 8'(cks_pkg::CPU_DLY_CYC - 1))
          next_r.state = cks_pkg::ST_RUN;
        else
          next_r.cpu_cnt = r.cpu_cnt + 8'h1;
      end
      default: next_r.state = cks_pkg::ST_RUN;
    endcase
    if (start)
      next_r.edge_cnt = 4'h0;
  end

  // single register bank, synchronous reset
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.clock_source_select <= cks_pkg::SCS_RESET;
      r.internal_freq_select <= cks_pkg::INTERNAL_FREQ_SELECT_RESET;
      r.fosc <= cks_pkg::FOSC_RESET;
      r.active <= cks_pkg::SEL_PRIMARY;
      r.target <= cks_pkg::SEL_PRIMARY;
      r.state <= cks_pkg::ST_RUN;
      r.primary_timeout_flag <= 1'b1;
      r.pri_on <= 1'b1;
    end
    else
      r <= next_r;
  end

  // outputs are all decoded from state flops or tied off
  assign hrdata = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign active_source = r.active;
  assign q1_hold = (r.state == cks_pkg::ST_HOLD) |
                   (r.state == cks_pkg::ST_CPU);
  assign primary_osc_on = r.pri_on;
  assign internal_osc_on = r.active == cks_pkg::SEL_INTERNAL |
                           r.target == cks_pkg::SEL_INTERNAL;
  assign secondary_osc_on = r.secondary_osc_enable | r.sec_keep;
endmodule

/* File: verification/cks_properties.sv */
`timescale 1ns/10ps
module cks_properties
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [1:0] active_source,
  input wire logic q1_hold,
  input wire logic primary_osc_on,
  input wire logic internal_osc_on,
  input wire logic secondary_osc_on
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // eight synchronised edges need at least eight core cycles
  sequence hold_span;
    q1_hold [*8] ##[0:1000] !q1_hold;
  endsequence
  a_bus_ready: assert property (hreadyout && !hresp)
    else $error("bus stalled or error response");
  a_hold_len: assert property ($rose(q1_hold) |-> hold_span)
    else $error("q1 hold too short or stuck");
  // a relabel onto an internal primary keeps the primary enable up
  a_src_after_hold: assert property ($changed(active_source) |->
    $past(q1_hold) || ($past(active_source) == cks_pkg::SEL_PRIMARY &&
    active_source == cks_pkg::SEL_INTERNAL && primary_osc_on))
    else $error("source changed without a hold");
  a_no_reserved: assert property (active_source != cks_pkg::SEL_RESERVED)
    else $error("reserved source active");
  a_prim_running: assert property
    (active_source == cks_pkg::SEL_PRIMARY && !q1_hold |-> primary_osc_on)
    else $error("running on stopped primary");
  a_sec_running: assert property
    (active_source == cks_pkg::SEL_SECONDARY |-> secondary_osc_on)
    else $error("running on stopped secondary");
  a_int_running: assert property
    (active_source == cks_pkg::SEL_INTERNAL |-> internal_osc_on)
    else $error("running on stopped internal");
  a_reset_state: assert property ($fell(sys_rst) |->
    active_source == cks_pkg::SEL_PRIMARY && !q1_hold && primary_osc_on)
    else $error("wrong state after reset");
endmodule

/* File: verification/cks_osc_model.sv */
`timescale 1ns/10ps
module cks_osc_model
(
  input wire logic core_clk,
  input wire logic primary_osc_on,
  input wire logic internal_osc_on,
  input wire logic secondary_osc_on,
  output logic primary_clk_pin,
  output logic internal_clk_pin,
  output logic secondary_clk_pin
);
  int pc = 0;
  int ic = 0;
  int sc = 0;
  initial
  begin
    primary_clk_pin = 1'b0;
    internal_clk_pin = 1'b0;
    secondary_clk_pin = 1'b0;
  end
  // stopped oscillators park low; all run below core/2 so no edge is lost
  always @(posedge core_clk)
  begin
    pc = primary_osc_on ? (pc + 1) % 2 : 0;
    ic = internal_osc_on ? (ic + 1) % 3 : 0;
    sc = secondary_osc_on ? (sc + 1) % 5 : 0;
    primary_clk_pin <= primary_osc_on && (primary_clk_pin ^ (pc == 0));
    internal_clk_pin <= internal_osc_on && (internal_clk_pin ^ (ic == 0));
    // only runs once enabled, so it is stable before any request
    secondary_clk_pin <= secondary_osc_on && (secondary_clk_pin ^ (sc == 0));
  end
endmodule

/* File: verification/system_clock_switch_sequencer_test.sv */
`timescale 1ns/10ps
module system_clock_switch_sequencer_test;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hsel = 1'b0;
  logic wake = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pri_pin;
  logic int_pin;
  logic sec_pin;
  logic [1:0] active_source;
  logic q1_hold;
  logic pri_on;
  logic int_on;
  logic sec_on;
  int n_mismatch = 0;
  int total_checks = 0;
  int hold_cyc;
  int wait_cyc;
  logic [31:0] lfsr = 32'hDCF2;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rd_seen;
  event rd_ev;
  cks_sequencer uut (.core_clk(core_clk), .sys_rst(sys_rst), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .primary_clk_pin(pri_pin),
    .internal_clk_pin(int_pin), .secondary_clk_pin(sec_pin),
    .wake_event(wake), .active_source(active_source), .q1_hold(q1_hold),
    .primary_osc_on(pri_on), .internal_osc_on(int_on),
    .secondary_osc_on(sec_on));
  cks_osc_model osc (.core_clk(core_clk), .primary_osc_on(pri_on),
    .internal_osc_on(int_on), .secondary_osc_on(sec_on),
    .primary_clk_pin(pri_pin), .internal_clk_pin(int_pin),
    .secondary_clk_pin(sec_pin));
  initial
  begin
    forever #20 core_clk = !core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one whole-word transfer; hready is sampled at each rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd_seen = hrdata;
  endtask
  // note the expectation, then let the monitor compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
    ->rd_ev;
  endtask
  task automatic wait_src(input logic [1:0] s);
    hold_cyc = 0;
    wait_cyc = 0;
    do
    begin
      @(negedge core_clk);
      wait_cyc++;
      hold_cyc += int'(q1_hold === 1'b1);
    end
    while (!(active_source === s && q1_hold === 1'b0) && wait_cyc < 20000);
    check("source", {30'h0, active_source}, {30'h0, s});
  endtask
  initial
  begin
    forever
    begin
      @(rd_ev);
      check("read data", rd_seen & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // whole sequence needs about 9000 cycles
  initial
  begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(cks_pkg::OSC_CTRL_OFS, 32'h8, 32'hB);
    rd(cks_pkg::CONFIG_OFS, 32'h2, 32'h7);
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    bus(1'b1, 8'h10, lfsr);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h1);
    rd(cks_pkg::OSC_CTRL_OFS, 32'h0, 32'h3);
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h3);
    rd(cks_pkg::OSC_CTRL_OFS, 32'h2, 32'h3);
    wait_src(cks_pkg::SEL_INTERNAL);
    check("primary on", {31'h0, pri_on}, 32'h0);
    rd(cks_pkg::OSC_CTRL_OFS, 32'h2, 32'hB);
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h1);
    rd(cks_pkg::OSC_CTRL_OFS, 32'h0, 32'h3);
    wait_src(cks_pkg::SEL_PRIMARY);
    check("start wait", {31'h0, wait_cyc >= 4096}, 32'h1);
    rd(cks_pkg::OSC_CTRL_OFS, 32'h8, 32'h8);
    bus(1'b1, cks_pkg::T1_CTRL_OFS, 32'h8);
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h1);
    wait_src(cks_pkg::SEL_SECONDARY);
    check("primary on", {31'h0, pri_on}, 32'h0);
    rd(cks_pkg::T1_CTRL_OFS, 32'h48, 32'h48);
    bus(1'b1, cks_pkg::T1_CTRL_OFS, 32'h0);
    rd(cks_pkg::OSC_CTRL_OFS, 32'h0, 32'h3);
    check("still secondary", {31'h0, sec_on}, 32'h1);
    wait_src(cks_pkg::SEL_PRIMARY);
    check("start wait", {31'h0, wait_cyc >= 4096}, 32'h1);
    rd(cks_pkg::T1_CTRL_OFS, 32'h0, 32'h40);
    bus(1'b1, cks_pkg::CONFIG_OFS, {29'h0, cks_pkg::FOSC_EXTERNAL_CLOCK});
    bus(1'b1, cks_pkg::T1_CTRL_OFS, 32'h8);
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h1);
    wait_src(cks_pkg::SEL_SECONDARY);
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h0);
    wait_src(cks_pkg::SEL_PRIMARY);
    check("cpu delay", {31'h0, hold_cyc >= cks_pkg::CPU_DLY_CYC}, 32'h1);
    bus(1'b1, cks_pkg::CONFIG_OFS, {29'h0, cks_pkg::FOSC_INTERNAL});
    bus(1'b1, cks_pkg::OSC_CTRL_OFS, 32'h2);
    hold_cyc = 0;
    repeat (60) @(negedge core_clk) hold_cyc += int'(q1_hold !== 1'b0);
    check("no switch", hold_cyc, 32'h0);
    // one-cycle wake while on the internal source parks the core
    @(posedge core_clk);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    hold_cyc = 0;
    repeat (300) @(negedge core_clk) hold_cyc += int'(q1_hold === 1'b1);
    check("wake delay", hold_cyc, 32'(cks_pkg::CPU_DLY_CYC));
    final_report();
  end
endmodule
bind cks_sequencer cks_properties u_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .hreadyout(hreadyout), .hresp(hresp),
  .active_source(active_source), .q1_hold(q1_hold),
  .primary_osc_on(primary_osc_on), .internal_osc_on(internal_osc_on),
  .secondary_osc_on(secondary_osc_on));
